// ### inc/tpg_regs.vh
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// Control and status slave word offsets
`define TPG_CSR_INFO 2'h0
`define TPG_CSR_CTRL 2'h1
`define TPG_CSR_LEVEL 2'h2

// Command slave word offsets
`define TPG_CMD_SEG 1'h0
`define TPG_CMD_ERR 1'h1

// Info fields
`define TPG_INFO_ID_LSB 0
`define TPG_INFO_CHAN_LSB 16
`define TPG_INFO_SPB_LSB 24
`define TPG_INFO_PKT_BIT 31

// Control fields
`define TPG_CTRL_EN_BIT 0
`define TPG_CTRL_THR_LSB 8
`define TPG_CTRL_THR_MSB 16
`define TPG_CTRL_SRST_BIT 17
`define TPG_CTRL_RESET 32'h00000000

// Queue level fields
`define TPG_LVL_BUSY_BIT 0
`define TPG_LVL_FILL_LSB 7

// Segment command fields
`define TPG_SEG_SIZE_MSB 15
`define TPG_SEG_CHAN_LSB 16
`define TPG_SEG_CHAN_MSB 29
`define TPG_SEG_SOP_BIT 30
`define TPG_SEG_EOP_BIT 31

// Error injection fields
`define TPG_ERR_SIG_MSB 15
`define TPG_ERR_MASK_LSB 16
`define TPG_ERR_MASK_MSB 23
`define TPG_ERR_NOSOP_BIT 24
`define TPG_ERR_NOEOP_BIT 25
`define TPG_ERR_RESET 32'h00000000

`endif

// ### src/tpg_cmd_fifo.v
`timescale 1ns/1ps
module tpg_cmd_fifo #(
  parameter WIDTH = 32,
  parameter AW = 4
) (
  // Clocking
  input wire clk,
  input wire ce,
  input wire rst_n,
  input wire clr,
  // Write side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  // Read side
  input wire rd_en,
  output reg [WIDTH-1:0] rd_data,
  // Status
  output reg [AW:0] count,
  output wire full,
  output wire empty
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  wire do_wr;
  wire do_rd;

  assign full = (count == DEPTH);
  assign empty = (count == {(AW+1){1'b0}});
  // Guard pointers so a careless caller cannot corrupt the count
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;

  ////////////////////////////////////////////////////////////////////
  // Storage has no reset, so it maps onto plain RAM
  always @(posedge clk)
  begin
    if (ce && do_wr)
      mem[wr_ptr_r] <= wr_data;
  end

  // Pointers, count and registered read data
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      rd_data <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      if (clr)
      begin
        wr_ptr_r <= {AW{1'b0}};
        rd_ptr_r <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
      end
      else
      begin
        if (do_wr)
          wr_ptr_r <= wr_ptr_r + 1'b1;
        if (do_rd)
        begin
          rd_ptr_r <= rd_ptr_r + 1'b1;
          rd_data <= mem[rd_ptr_r];
        end
        if (do_wr && !do_rd)
          count <= count + 1'b1;
        else if (do_rd && !do_wr)
          count <= count - 1'b1;
      end
    end
  end

endmodule

// ### src/tpg_top.v
// Operation
// - Info returns identity, channels, symbols per beat
// - Info bit 31 shows packet capability
// - Control bit 0 enables generation
// - Throttle field compared with pseudorandom number
// - Throttle 0 stops, 256 full rate
// - Soft reset bit holds counters cleared
// - Busy bit: transmitting or commands queued
// - Level bits 15:7 give FIFO count
// - Only segment command writes push FIFO
// - Pad non-last segments to whole beats
// - Channel driven from low field bits
// - Start flag marks packet start if capable
// - End flag marks packet end if capable
// - Error field drives output error signal
// - Data mask XORed into every symbol
// - Drop start marker on request
// - Drop end marker on request
// - Status registers at words 0, 1, 2
// - Sixteen-entry FIFO stalls writes when full
// - Symbol equals packet position XOR mask
// - Injected errors persist until cleared
// - Separate position state per channel
`timescale 1ns/1ps
`include "tpg_regs.vh"
module tpg_top #(
  parameter NUM_CHANNELS = 4,
  parameter CHANNEL_WIDTH = 2,
  parameter BITS_PER_SYMBOL = 8,
  parameter SYMBOLS_PER_BEAT = 4,
  parameter EMPTY_WIDTH = 2,
  parameter ERROR_WIDTH = 1,
  parameter PACKETS = 1,
  parameter FIFO_AW = 4,
  parameter [15:0] THROTTLE_SEED = 16'hACE1,
  // Identity value is arbitrary
  parameter [15:0] IDENTITY_VALUE = 16'h5A3C
) (
  // Clock, enable, reset
  input wire CLK,
  input wire CE,
  input wire ARST_N,
  // Control and status slave
  input wire [1:0] CSR_ADDRESS,
  input wire CSR_READ,
  input wire CSR_WRITE,
  input wire [31:0] CSR_WRITEDATA,
  output reg [31:0] CSR_READDATA,
  // Command slave
  input wire CMD_ADDRESS,
  input wire CMD_WRITE,
  input wire [31:0] CMD_WRITEDATA,
  output wire CMD_WAITREQUEST,
  // Stream output
  output wire OUT_VALID,
  input wire OUT_READY,
  output reg [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] OUT_DATA,
  output reg [CHANNEL_WIDTH-1:0] OUT_CHANNEL,
  output reg OUT_SOP,
  output reg OUT_EOP,
  output reg [EMPTY_WIDTH-1:0] OUT_EMPTY,
  output reg [ERROR_WIDTH-1:0] OUT_ERROR
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOAD = 2'h1;
  localparam [1:0] S_RUN = 2'h2;
  localparam [16:0] SPB17 = SYMBOLS_PER_BEAT[16:0];
  localparam [31:0] SPB32 = SYMBOLS_PER_BEAT;
  localparam PKT_ON = (PACKETS != 0);

  ////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  reg rst_s1_r;
  reg rst_n_r;

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software registers
  reg ctrl_en_r;
  reg [8:0] ctrl_thr_r;
  reg ctrl_srst_r;
  reg [31:0] err_r;
  wire csr_wr_ctrl;
  wire seg_push;
  wire err_wr;
  wire fifo_full;
  wire fifo_empty;
  wire [FIFO_AW:0] fifo_count;
  wire [31:0] fifo_rd_data;
  localparam [31:0] CTRL_RST = `TPG_CTRL_RESET;

  assign csr_wr_ctrl = CSR_WRITE && (CSR_ADDRESS == `TPG_CSR_CTRL);
  // Only the segment word pushes; stalled while full or frozen
  assign seg_push = CE && CMD_WRITE && (CMD_ADDRESS == `TPG_CMD_SEG) && !fifo_full;
  assign err_wr = CMD_WRITE && (CMD_ADDRESS == `TPG_CMD_ERR);
  // Master must hold its write until this drops
  assign CMD_WAITREQUEST = CMD_WRITE && (CMD_ADDRESS == `TPG_CMD_SEG)
                           && (fifo_full || !CE);

  // Control and error injection storage; errors stay until rewritten
  always @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ctrl_en_r <= CTRL_RST[`TPG_CTRL_EN_BIT];
      ctrl_thr_r <= CTRL_RST[`TPG_CTRL_THR_MSB:`TPG_CTRL_THR_LSB];
      ctrl_srst_r <= CTRL_RST[`TPG_CTRL_SRST_BIT];
      err_r <= `TPG_ERR_RESET;
    end
    else if (CE)
    begin
      if (csr_wr_ctrl)
      begin
        ctrl_en_r <= CSR_WRITEDATA[`TPG_CTRL_EN_BIT];
        ctrl_thr_r <= CSR_WRITEDATA[`TPG_CTRL_THR_MSB:`TPG_CTRL_THR_LSB];
        ctrl_srst_r <= CSR_WRITEDATA[`TPG_CTRL_SRST_BIT];
      end
      if (err_wr)
        err_r <= {6'h00, CMD_WRITEDATA[25:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read mux, one cycle of latency
  reg [1:0] state_r;
  reg out_valid_r;
  wire busy;

  assign busy = (state_r != S_IDLE) || out_valid_r || !fifo_empty;

  always @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      CSR_READDATA <= 32'h00000000;
    else if (CE && CSR_READ)
    begin
      case (CSR_ADDRESS)
        `TPG_CSR_INFO:
        begin
          CSR_READDATA <= 32'h00000000;
          CSR_READDATA[15:`TPG_INFO_ID_LSB] <= IDENTITY_VALUE;
          CSR_READDATA[23:`TPG_INFO_CHAN_LSB] <= NUM_CHANNELS[7:0];
          CSR_READDATA[30:`TPG_INFO_SPB_LSB] <= SYMBOLS_PER_BEAT[6:0];
          CSR_READDATA[`TPG_INFO_PKT_BIT] <= PKT_ON;
        end
        `TPG_CSR_CTRL:
          CSR_READDATA <= {14'h0000, ctrl_srst_r, ctrl_thr_r, 7'h00, ctrl_en_r};
        `TPG_CSR_LEVEL:
        begin
          CSR_READDATA <= 32'h00000000;
          CSR_READDATA[`TPG_LVL_BUSY_BIT] <= busy;
          CSR_READDATA[15:`TPG_LVL_FILL_LSB] <= {{(8-FIFO_AW){1'b0}}, fifo_count};
        end
        default:
          CSR_READDATA <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command queue
  wire fifo_pop;

  tpg_cmd_fifo #(
    .WIDTH(32),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .ce(CE),
    .rst_n(rst_n_r),
    .clr(ctrl_srst_r),
    .wr_en(seg_push),
    .wr_data(CMD_WRITEDATA),
    .rd_en(fifo_pop),
    .rd_data(fifo_rd_data),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////
  // Throttle: 16-bit LFSR, top byte against the throttle value
  reg [15:0] lfsr_r;
  wire throttle_ok;

  always @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      lfsr_r <= THROTTLE_SEED;
    else if (CE)
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  // Byte tops out at 255, so 256 always passes and 0 never does
  assign throttle_ok = ({1'b0, lfsr_r[15:8]} < ctrl_thr_r);

  ////////////////////////////////////////////////////////////////////
  // Segment engine
  reg [16:0] rem_r;
  reg [CHANNEL_WIDTH-1:0] chan_r;
  reg seg_sop_r;
  reg seg_eop_r;
  reg first_beat_r;
  reg [31:0] seg_pos_r;
  reg [31:0] pos_r [0:NUM_CHANNELS-1];
  wire [13:0] cmd_chan;
  wire [CHANNEL_WIDTH-1:0] cmd_chan_n;
  wire [CHANNEL_WIDTH-1:0] chan_idx;
  wire last_beat;
  wire fire;
  wire pos_we;
  wire [31:0] pos_wb;

  assign cmd_chan = fifo_rd_data[`TPG_SEG_CHAN_MSB:`TPG_SEG_CHAN_LSB];
  assign cmd_chan_n = cmd_chan[CHANNEL_WIDTH-1:0];
  // Channels past the configured count share slot zero
  assign chan_idx = (chan_r < NUM_CHANNELS) ? chan_r : {CHANNEL_WIDTH{1'b0}};
  assign fifo_pop = (state_r == S_IDLE) && ctrl_en_r && !fifo_empty && !ctrl_srst_r;
  assign last_beat = (rem_r <= SPB17);
  assign fire = (state_r == S_RUN) && ctrl_en_r && throttle_ok
                && (!out_valid_r || OUT_READY) && !ctrl_srst_r;
  assign pos_we = fire && last_beat;
  // A packet's end restarts the channel; plain streams never end
  assign pos_wb = (seg_eop_r && PKT_ON) ? 32'h00000000 : seg_pos_r + SPB32;

  // Sequencer for fetching and running segments
  always @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= S_IDLE;
      rem_r <= 17'h00000;
      chan_r <= {CHANNEL_WIDTH{1'b0}};
      seg_sop_r <= 1'b0;
      seg_eop_r <= 1'b0;
      first_beat_r <= 1'b0;
      seg_pos_r <= 32'h00000000;
    end
    else if (CE)
    begin
      if (ctrl_srst_r)
        state_r <= S_IDLE;
      else
      begin
        case (state_r)
          S_IDLE:
            if (fifo_pop)
              state_r <= S_LOAD;
          S_LOAD:
          begin
            rem_r <= {1'b0, fifo_rd_data[`TPG_SEG_SIZE_MSB:0]};
            chan_r <= cmd_chan_n;
            seg_sop_r <= fifo_rd_data[`TPG_SEG_SOP_BIT] && PKT_ON;
            seg_eop_r <= fifo_rd_data[`TPG_SEG_EOP_BIT] && PKT_ON;
            first_beat_r <= 1'b1;
            // Zero-length segments are dropped
            if (fifo_rd_data[`TPG_SEG_SIZE_MSB:0] == 16'h0000)
              state_r <= S_IDLE;
            else
              state_r <= S_RUN;
          end
          S_RUN:
            if (fire)
            begin
              first_beat_r <= 1'b0;
              seg_pos_r <= seg_pos_r + SPB32;
              rem_r <= last_beat ? 17'h00000 : rem_r - SPB17;
              if (last_beat)
                state_r <= S_IDLE;
            end
          default:
            state_r <= S_IDLE;
        endcase
        // Segment start position: zero at packet start, else resume
        if (state_r == S_LOAD)
        begin
          if (fifo_rd_data[`TPG_SEG_SOP_BIT] && PKT_ON)
            seg_pos_r <= 32'h00000000;
          else if (cmd_chan_n < NUM_CHANNELS)
            seg_pos_r <= pos_r[cmd_chan_n];
          else
            seg_pos_r <= pos_r[0];
        end
      end
    end
  end

  // Per-channel symbol position, written back at segment end
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHANNELS; gc = gc + 1)
    begin : g_chan
      always @(posedge CLK or negedge rst_n_r)
      begin
        if (!rst_n_r)
          pos_r[gc] <= 32'h00000000;
        else if (CE)
        begin
          if (ctrl_srst_r)
            pos_r[gc] <= 32'h00000000;
          else if (pos_we && (chan_idx == gc))
            pos_r[gc] <= pos_wb;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Beat assembly; symbol 0 sits in the top lane
  wire [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] beat_data;
  wire [31:0] mask32;
  wire [16:0] empty_full;

  assign mask32 = {24'h000000, err_r[`TPG_ERR_MASK_MSB:`TPG_ERR_MASK_LSB]};
  assign empty_full = SPB17 - rem_r;

  genvar gs;
  generate
    for (gs = 0; gs < SYMBOLS_PER_BEAT; gs = gs + 1)
    begin : g_sym
      wire [31:0] sym_pos;
      assign sym_pos = seg_pos_r + gs;
      // Pad symbols continue the pattern; mask applies to all
      assign beat_data[BITS_PER_SYMBOL*(SYMBOLS_PER_BEAT-gs)-1 -: BITS_PER_SYMBOL] =
        sym_pos[BITS_PER_SYMBOL-1:0] ^ mask32[BITS_PER_SYMBOL-1:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Output register stage; beat holds until taken, but soft reset drops it
  assign OUT_VALID = out_valid_r;

  always @(posedge CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      out_valid_r <= 1'b0;
      OUT_DATA <= {(BITS_PER_SYMBOL*SYMBOLS_PER_BEAT){1'b0}};
      OUT_CHANNEL <= {CHANNEL_WIDTH{1'b0}};
      OUT_SOP <= 1'b0;
      OUT_EOP <= 1'b0;
      OUT_EMPTY <= {EMPTY_WIDTH{1'b0}};
      OUT_ERROR <= {ERROR_WIDTH{1'b0}};
    end
    else if (CE)
    begin
      if (ctrl_srst_r)
        out_valid_r <= 1'b0;
      else if (fire)
      begin
        out_valid_r <= 1'b1;
        OUT_DATA <= beat_data;
        OUT_CHANNEL <= chan_r;
        OUT_SOP <= seg_sop_r && first_beat_r && !err_r[`TPG_ERR_NOSOP_BIT];
        OUT_EOP <= seg_eop_r && last_beat && !err_r[`TPG_ERR_NOEOP_BIT];
        // Only a packet's final beat may be short
        if (seg_eop_r && last_beat)
          OUT_EMPTY <= empty_full[EMPTY_WIDTH-1:0];
        else
          OUT_EMPTY <= {EMPTY_WIDTH{1'b0}};
        OUT_ERROR <= err_r[ERROR_WIDTH-1:0];
      end
      else if (OUT_READY)
        out_valid_r <= 1'b0;
    end
  end

endmodule

// ### dv/tpg_chk.sv
`timescale 1ns/1ps
module tpg_chk #(
  parameter NUM_CHANNELS = 4,
  parameter BITS_PER_SYMBOL = 8,
  parameter SYMBOLS_PER_BEAT = 4,
  parameter EMPTY_WIDTH = 2,
  parameter PACKETS = 1,
  parameter [15:0] IDENTITY_VALUE = 16'h5A3C
) (
  // Clock and reset
  input wire CLK,
  input wire CE,
  input wire ARST_N,
  // Register slaves
  input wire [1:0] CSR_ADDRESS,
  input wire CSR_READ,
  input wire CSR_WRITE,
  input wire [31:0] CSR_WRITEDATA,
  input wire [31:0] CSR_READDATA,
  input wire CMD_ADDRESS,
  input wire CMD_WRITE,
  input wire CMD_WAITREQUEST,
  // Stream
  input wire OUT_VALID,
  input wire OUT_READY,
  input wire [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] OUT_DATA,
  input wire OUT_EOP,
  input wire [EMPTY_WIDTH-1:0] OUT_EMPTY
);
  localparam [31:0] INFO = {PACKETS != 0, 7'(SYMBOLS_PER_BEAT), 8'(NUM_CHANNELS), IDENTITY_VALUE};
  wire ctl_wr = CE && CSR_WRITE && CSR_ADDRESS == 2'h1;
  reg en_r;
  reg srst_r;
  reg [8:0] thr_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow control word, as enable and throttle never reach the ports
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      en_r <= 1'b0;
      srst_r <= 1'b0;
      thr_r <= 9'h000;
    end
    else if (ctl_wr)
    begin
      en_r <= CSR_WRITEDATA[0];
      srst_r <= CSR_WRITEDATA[17];
      thr_r <= CSR_WRITEDATA[16:8];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  info_read_a: assert property (CE && CSR_READ && CSR_ADDRESS == 2'h0 |=>
    CSR_READDATA == INFO) else $error("info word wrong");
  ctrl_back_a: assert property (ctl_wr ##1 CE && CSR_READ && CSR_ADDRESS == 2'h1 &&
    !CSR_WRITE |=> CSR_READDATA == ($past(CSR_WRITEDATA, 2) & 32'h0003FF01))
    else $error("control readback wrong");
  level_fmt_a: assert property (CE && CSR_READ && CSR_ADDRESS == 2'h2 |=>
    CSR_READDATA[31:16] == 16'h0 && CSR_READDATA[6:1] == 6'h0 &&
    (CSR_READDATA[15:7] == 9'h0 || CSR_READDATA[0])) else $error("level word wrong");
  spare_read_a: assert property (CE && CSR_READ && CSR_ADDRESS == 2'h3 |=>
    CSR_READDATA == 32'h0) else $error("spare word not zero");
  err_nostall_a: assert property (CE && CMD_WRITE && CMD_ADDRESS |->
    !CMD_WAITREQUEST) else $error("error word stalled");
  no_beat_off_a: assert property ($rose(OUT_VALID) |-> en_r || $past(en_r))
    else $error("beat while disabled");
  thr_zero_a: assert property ($rose(OUT_VALID) |-> thr_r != 9'h0 || $past(thr_r) != 9'h0)
    else $error("beat at zero throttle");
  srst_hold_a: assert property (srst_r && $past(srst_r) |-> !OUT_VALID)
    else $error("beat in soft reset");
  beat_hold_a: assert property (OUT_VALID && !OUT_READY && CE && !srst_r &&
    !(ctl_wr && CSR_WRITEDATA[17]) |=> OUT_VALID && $stable(OUT_DATA))
    else $error("stalled beat changed");
  empty_eop_a: assert property (OUT_VALID && !OUT_EOP |-> OUT_EMPTY == 0)
    else $error("empty off end beat");
endmodule

// ### dv/tpg_sink_model.sv
`timescale 1ns/1ps
module tpg_sink_model (
  // Stream in
  input wire clk,
  input wire valid,
  input wire [38:0] beat,
  // Pacing
  input wire slow,
  output reg ready
);
  logic [38:0] got_q[$];
  initial ready = 1'b0;
  // Toggling ready when slow forces the source to hold beats
  always @(posedge clk)
  begin
    if (valid && ready)
      got_q.push_back(beat);
    ready <= slow ? !ready : 1'b1;
  end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [1:0] a; logic w; logic [31:0] d; logic [31:0] e;} tpg_row_t;
  reg CLK, CE, ARST_N, CSR_READ, CSR_WRITE, CMD_ADDRESS, CMD_WRITE, slow;
  reg [1:0] CSR_ADDRESS;
  reg [31:0] CSR_WRITEDATA, CMD_WRITEDATA, rd;
  wire [31:0] CSR_READDATA, OUT_DATA;
  wire [1:0] OUT_CHANNEL, OUT_EMPTY;
  wire [0:0] OUT_ERROR;
  wire OUT_VALID, OUT_READY, OUT_SOP, OUT_EOP, CMD_WAITREQUEST;
  integer bad_count = 0, tests_run = 0, cyc = 0, i, stalls;
  tpg_row_t rows [0:7];
  tpg_top i_tpg_top (.CLK(CLK), .CE(CE), .ARST_N(ARST_N), .CSR_ADDRESS(CSR_ADDRESS),
    .CSR_READ(CSR_READ), .CSR_WRITE(CSR_WRITE), .CSR_WRITEDATA(CSR_WRITEDATA),
    .CSR_READDATA(CSR_READDATA), .CMD_ADDRESS(CMD_ADDRESS), .CMD_WRITE(CMD_WRITE),
    .CMD_WRITEDATA(CMD_WRITEDATA), .CMD_WAITREQUEST(CMD_WAITREQUEST), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_CHANNEL(OUT_CHANNEL), .OUT_SOP(OUT_SOP),
    .OUT_EOP(OUT_EOP), .OUT_EMPTY(OUT_EMPTY), .OUT_ERROR(OUT_ERROR));
  tpg_sink_model i_tpg_sink_model (.clk(CLK), .valid(OUT_VALID), .slow(slow), .ready(OUT_READY),
    .beat({OUT_ERROR, OUT_EMPTY, OUT_EOP, OUT_SOP, OUT_CHANNEL, OUT_DATA}));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task wrap_up;
  begin
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk_reg(input string n, input [31:0] e, input [31:0] g);
  begin
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task chk_beat(input [38:0] e, input [38:0] g);
  begin
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] beat exp %h got %h", e, g);
    end
  end
  endtask
  // Write strobe is left up; the next access lowers or reuses it
  task csr_wr(input [1:0] a, input [31:0] d);
  begin
    @(negedge CLK);
    {CSR_READ, CSR_WRITE, CSR_ADDRESS, CSR_WRITEDATA} = {2'b01, a, d};
    @(posedge CLK);
  end
  endtask
  task csr_rd(input [1:0] a);
  begin
    @(negedge CLK);
    {CSR_READ, CSR_WRITE, CSR_ADDRESS} = {2'b10, a};
    @(negedge CLK);
    CSR_READ = 1'b0;
    rd = CSR_READDATA;
  end
  endtask
  // Request held until waitrequest is seen low at the taking edge
  task cmd_wr(input a, input [31:0] d);
  begin
    @(negedge CLK);
    {CMD_WRITE, CMD_ADDRESS, CMD_WRITEDATA} = {1'b1, a, d};
    stalls = 0;
    #1;
    while (CMD_WAITREQUEST !== 1'b0 && stalls < 400)
    begin
      @(negedge CLK);
      #1;
      stalls++;
    end
    if (stalls >= 400)
      bad_count++;
    @(negedge CLK);
    CMD_WRITE = 1'b0;
  end
  endtask
  // Empty symbols carry no defined value, so they are masked out
  task expect_beat(input [6:0] f, input [31:0] d);
    logic [38:0] e, g;
    logic [31:0] m;
  begin
    e = {f, d};
    for (i = 0; i < 200 && i_tpg_sink_model.got_q.size() == 0; i++)
      @(negedge CLK);
    g = i_tpg_sink_model.got_q.size() > 0 ? i_tpg_sink_model.got_q.pop_front() : 'x;
    m = 32'hFFFFFFFF << (8 * f[5:4]);
    chk_beat({e[38:32], e[31:0] & m}, {g[38:32], g[31:0] & m});
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; beat flags are {error, empty[1:0], eop, sop, channel[1:0]}
  initial
  begin
    {CE, ARST_N, CSR_READ, CSR_WRITE, CMD_ADDRESS, CMD_WRITE, slow} = 7'b1000000;
    {CSR_ADDRESS, CSR_WRITEDATA, CMD_WRITEDATA} = 66'h0;
    rows[0] = {2'h0, 1'b0, 32'h0, 32'h84045A3C};
    rows[1] = {2'h1, 1'b0, 32'h0, 32'h0};
    rows[2] = {2'h2, 1'b0, 32'h0, 32'h0};
    rows[3] = {2'h1, 1'b1, 32'hFFFFFFFF, 32'h0003FF01};
    rows[4] = {2'h0, 1'b1, 32'hDEADBEEF, 32'h84045A3C};
    rows[5] = {2'h2, 1'b1, 32'hFFFFFFFF, 32'h0};
    rows[6] = {2'h3, 1'b1, 32'hFFFFFFFF, 32'h0};
    rows[7] = {2'h1, 1'b1, 32'h00010000, 32'h00010000};
    repeat (6) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (3) @(negedge CLK);
    for (int r = 0; r < 8; r++)
    begin
      if (rows[r].w)
        csr_wr(rows[r].a, rows[r].d);
      csr_rd(rows[r].a);
      chk_reg("csr word", rows[r].e, rd);
    end
    $display("register table done");
    csr_wr(2'h1, 32'h00010001);
    cmd_wr(1'b0, 32'hFFFD0006);
    expect_beat(7'h05, 32'h00010203);
    expect_beat(7'h29, 32'h04050607);
    repeat (4) @(negedge CLK);
    csr_rd(2'h2);
    chk_reg("level idle", 32'h0, rd);
    $display("walk done");
    slow = 1'b1;
    cmd_wr(1'b0, 32'h40020005);
    cmd_wr(1'b0, 32'hC0030004);
    cmd_wr(1'b0, 32'h80020003);
    expect_beat(7'h06, 32'h00010203);
    expect_beat(7'h02, 32'h04050607);
    expect_beat(7'h0F, 32'h00010203);
    expect_beat(7'h1A, 32'h08090A00);
    slow = 1'b0;
    $display("interleave done");
    cmd_wr(1'b1, 32'h035A0001);
    cmd_wr(1'b0, 32'hC0000004);
    expect_beat(7'h40, 32'h5A5B5859);
    cmd_wr(1'b0, 32'hC0000004);
    expect_beat(7'h40, 32'h5A5B5859);
    cmd_wr(1'b1, 32'h0);
    cmd_wr(1'b0, 32'hC0000004);
    expect_beat(7'h0C, 32'h00010203);
    $display("error injection done");
    csr_wr(2'h1, 32'h00010000);
    for (int k = 0; k < 16; k++)
      cmd_wr(1'b0, 32'hC0000004);
    csr_rd(2'h2);
    chk_reg("level full", 32'h00000801, rd);
    chk_reg("beats off", 32'h0, i_tpg_sink_model.got_q.size());
    fork
      cmd_wr(1'b0, 32'hC0000004);
      begin
        repeat (10) @(posedge CLK);
        csr_wr(2'h1, 32'h00010001);
      end
    join
    chk_reg("stalled", 32'h1, {31'h0, stalls >= 10});
    for (int k = 0; k < 17; k++)
      expect_beat(7'h0C, 32'h00010203);
    $display("queue full done");
    csr_wr(2'h1, 32'h00000001);
    cmd_wr(1'b0, 32'hC0000004);
    repeat (40) @(negedge CLK);
    chk_reg("throttle zero", 32'h0, i_tpg_sink_model.got_q.size());
    csr_rd(2'h2);
    chk_reg("busy", 32'h1, rd & 32'h1);
    csr_wr(2'h1, 32'h00020001);
    // Soft reset clears the engine one edge after the write lands
    @(negedge CLK);
    csr_rd(2'h2);
    chk_reg("level soft", 32'h0, rd);
    csr_wr(2'h1, 32'h00010001);
    repeat (20) @(negedge CLK);
    chk_reg("flushed", 32'h0, i_tpg_sink_model.got_q.size());
    cmd_wr(1'b0, 32'hC0000004);
    expect_beat(7'h0C, 32'h00010203);
    $display("throttle and soft reset done");
    // Clock enable low: neither the write nor the read may be taken
    CE = 1'b0;
    csr_wr(2'h1, 32'h0);
    csr_rd(2'h1);
    CE = 1'b1;
    csr_rd(2'h1);
    chk_reg("ce frozen", 32'h00010001, rd);
    $display("clock enable done");
    ARST_N = 1'b0;
    repeat (2) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (3) @(negedge CLK);
    csr_rd(2'h1);
    chk_reg("ctrl reset", 32'h0, rd);
    $display("reset done");
    wrap_up;
  end
endmodule
bind tpg_top tpg_chk #(.NUM_CHANNELS(NUM_CHANNELS), .BITS_PER_SYMBOL(BITS_PER_SYMBOL),
  .SYMBOLS_PER_BEAT(SYMBOLS_PER_BEAT), .EMPTY_WIDTH(EMPTY_WIDTH), .PACKETS(PACKETS),
  .IDENTITY_VALUE(IDENTITY_VALUE)) i_tpg_chk (.CLK(CLK), .CE(CE), .ARST_N(ARST_N),
  .CSR_ADDRESS(CSR_ADDRESS), .CSR_READ(CSR_READ), .CSR_WRITE(CSR_WRITE),
  .CSR_WRITEDATA(CSR_WRITEDATA), .CSR_READDATA(CSR_READDATA), .CMD_ADDRESS(CMD_ADDRESS),
  .CMD_WRITE(CMD_WRITE), .CMD_WAITREQUEST(CMD_WAITREQUEST), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_EOP(OUT_EOP), .OUT_EMPTY(OUT_EMPTY));
